// ### design/ifeb_pkg.sv
package ifeb_pkg;

  // Byte offsets on the register bus, one aligned 32-bit word each
  localparam int unsigned ADDR_W          = 5;
  localparam logic [4:0]  OFS_FLAGS3      = 5'h00;
  localparam logic [4:0]  OFS_FLAGS4      = 5'h04;
  localparam logic [4:0]  OFS_FLAGS5      = 5'h08;
  localparam logic [4:0]  OFS_ENABLES0    = 5'h0C;
  localparam logic [4:0]  OFS_IRQ_STATUS  = 5'h10;
  localparam logic [4:0]  OFS_IRQ_MASK    = 5'h14;

  // Implemented bits of each 16-bit register
  localparam logic [15:0] MASK_FLAGS3     = 16'h4066;
  localparam logic [15:0] MASK_FLAGS4     = 16'h210E;
  localparam logic [15:0] MASK_FLAGS5     = 16'h3FFE;
  localparam logic [15:0] MASK_ENABLES0   = 16'h3FEF;
  localparam logic [15:0] RST_REG         = 16'h0000;

  // Interrupt status and mask: one bit per flag register
  localparam int unsigned EVT_W           = 3;
  localparam logic [2:0]  MASK_EVT        = 3'h7;
  localparam logic [2:0]  RST_EVT         = 3'h0;
  localparam int unsigned NGRP            = 3;

  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ifeb_avs_req_t;

  typedef struct packed {
    logic       pad15;
    logic       calendar_clock_flag;
    logic [6:0] pad13_7;
    logic       ext_input4_flag;
    logic       ext_input3_flag;
    logic [1:0] pad4_3;
    logic       i2c2_master_flag;
    logic       i2c2_slave_flag;
    logic       pad0;
  } ifeb_flags3_t;

  typedef struct packed {
    logic [1:0] pad15_14;
    logic       time_measure_flag;
    logic [3:0] pad12_9;
    logic       low_voltage_flag;
    logic [3:0] pad7_4;
    logic       crc_gen_flag;
    logic       uart2_error_flag;
    logic       uart1_error_flag;
    logic       pad0;
  } ifeb_flags4_t;

  typedef struct packed {
    logic [1:0] pad15_14;
    logic       capture9_flag;
    logic       compare9_flag;
    logic       spi3_event_flag;
    logic       spi3_fault_flag;
    logic       uart4_tx_flag;
    logic       uart4_rx_flag;
    logic       uart4_error_flag;
    logic       usb_event_flag;
    logic       i2c3_master_flag;
    logic       i2c3_slave_flag;
    logic       uart3_tx_flag;
    logic       uart3_rx_flag;
    logic       uart3_error_flag;
    logic       pad0;
  } ifeb_flags5_t;

  typedef struct packed {
    logic [1:0] pad15_14;
    logic       adc_done_enable;
    logic       uart1_tx_enable;
    logic       uart1_rx_enable;
    logic       spi1_transfer_enable;
    logic       spi1_fault_enable;
    logic       timer3_irq_enable;
    logic       timer2_irq_enable;
    logic       compare2_enable;
    logic       capture2_enable;
    logic       pad4;
    logic       timer1_irq_enable;
    logic       compare1_enable;
    logic       capture1_enable;
    logic       ext_input0_enable;
  } ifeb_enables0_t;

endpackage

// ### design/ifeb_top.sv
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps

// How it works
// - Flags3: calendar clock at 14, ext input 4 at 6 and 3 at 5, I2C2 master at 2, slave at 1.
// - Bits 15, 13..7, 4..3 and 0 of the third flag register read zero and ignore writes.
// - Flags4: time measure 13, low voltage 8, CRC 3, UART2 error 2, UART1 error 1.
// - Bits 15..14, 12..9, 7..4 and 0 of the fourth flag register read zero.
// - Flags5 bits 13..8: capture9, compare9, SPI3 event, fault, UART4 tx, rx; 15..14 zero.
// - Flags5 bits 7..1: UART4 error, USB, I2C3 master, slave, UART3 tx, rx, error; 0 zero.
// - Enables bits 13..8: ADC done, UART1 tx, rx, SPI1 transfer, fault, timer 3; 15..14 zero.
// - Enables 7..5 timer2, compare2, capture2; 3..0 timer1, compare1, capture1, ext0; 4 zero.
// - A flag bit reads one once its source requested, and software may read and write it.
// - A set enable bit lets its source's request through; software may read and write it.
// - All flag and enable bits are zero after power-on reset.
module ifeb_top (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire ifeb_pkg::ifeb_avs_req_t  avs_req,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  input  wire ifeb_pkg::ifeb_flags3_t   src_flags3,
  input  wire ifeb_pkg::ifeb_flags4_t   src_flags4,
  input  wire ifeb_pkg::ifeb_flags5_t   src_flags5,
  input  wire logic [15:0]              flags0_in,
  input  wire logic [15:0]              en3_in,
  input  wire logic [15:0]              en4_in,
  input  wire logic [15:0]              en5_in,
  output ifeb_pkg::ifeb_flags3_t        req3,
  output ifeb_pkg::ifeb_flags4_t        req4,
  output ifeb_pkg::ifeb_flags5_t        req5,
  output ifeb_pkg::ifeb_enables0_t      req0,
  output logic                          irq
);

  localparam logic [15:0] FLAG_MASK [ifeb_pkg::NGRP] = '{
    ifeb_pkg::MASK_FLAGS3, ifeb_pkg::MASK_FLAGS4, ifeb_pkg::MASK_FLAGS5};
  localparam logic [4:0]  FLAG_OFS  [ifeb_pkg::NGRP] = '{
    ifeb_pkg::OFS_FLAGS3, ifeb_pkg::OFS_FLAGS4, ifeb_pkg::OFS_FLAGS5};

  logic [15:0]                flag_q [ifeb_pkg::NGRP];
  logic [15:0]                set_v  [ifeb_pkg::NGRP];
  logic [15:0]                en0_q;
  logic [ifeb_pkg::EVT_W-1:0] status_q;
  logic [ifeb_pkg::EVT_W-1:0] mask_q;
  logic [ifeb_pkg::EVT_W-1:0] evt_d;
  logic [15:0]                rdata_d;
  logic [15:0]                wmask;
  logic [4:0]                 addr;
  logic                       accept;
  logic                       wr_acc;
  logic                       rd_acc;

  // Sources sit on this clock, so their pulses are used as they come
  assign set_v[0] = src_flags3 & ifeb_pkg::MASK_FLAGS3;
  assign set_v[1] = src_flags4 & ifeb_pkg::MASK_FLAGS4;
  assign set_v[2] = src_flags5 & ifeb_pkg::MASK_FLAGS5;

  assign addr   = {avs_req.address[4:2], 2'b00};
  assign accept = (avs_req.read | avs_req.write) & ~avs_waitrequest;
  assign wr_acc = accept & avs_req.write;
  assign rd_acc = accept & avs_req.read;
  assign wmask  = {{8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};

  // Flag registers: hardware set beats a software write in the same cycle
  for (genvar g = 0; g < ifeb_pkg::NGRP; g++)
  begin : g_flag
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        flag_q[g] <= ifeb_pkg::RST_REG;
      end
      else if (wr_acc && addr == FLAG_OFS[g])
      begin
        flag_q[g] <= ((flag_q[g] & ~wmask) | (avs_req.writedata[15:0] & wmask) | set_v[g])
                     & FLAG_MASK[g];
      end
      else
      begin
        flag_q[g] <= flag_q[g] | set_v[g];
      end
    end
    assign evt_d[g] = |set_v[g];
  end

  // Enable register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      en0_q <= ifeb_pkg::RST_REG;
    end
    else if (wr_acc && addr == ifeb_pkg::OFS_ENABLES0)
    begin
      en0_q <= ((en0_q & ~wmask) | (avs_req.writedata[15:0] & wmask))
               & ifeb_pkg::MASK_ENABLES0;
    end
  end

  // Sticky status, cleared only for the bits the read actually returned
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      status_q <= ifeb_pkg::RST_EVT;
    end
    else if (rd_acc && addr == ifeb_pkg::OFS_IRQ_STATUS)
    begin
      status_q <= (status_q & ~avs_readdata[ifeb_pkg::EVT_W-1:0]) | evt_d;
    end
    else
    begin
      status_q <= status_q | evt_d;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mask_q <= ifeb_pkg::RST_EVT;
    end
    else if (wr_acc && addr == ifeb_pkg::OFS_IRQ_MASK && avs_req.byteenable[0])
    begin
      mask_q <= avs_req.writedata[ifeb_pkg::EVT_W-1:0] & ifeb_pkg::MASK_EVT;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(status_q & mask_q);
    end
  end

  // Requests to the core, gated by their matching enables
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      req3 <= '0;
      req4 <= '0;
      req5 <= '0;
      req0 <= '0;
    end
    else
    begin
      req3 <= ifeb_pkg::ifeb_flags3_t'(flag_q[0] & en3_in);
      req4 <= ifeb_pkg::ifeb_flags4_t'(flag_q[1] & en4_in);
      req5 <= ifeb_pkg::ifeb_flags5_t'(flag_q[2] & en5_in);
      req0 <= ifeb_pkg::ifeb_enables0_t'(flags0_in & en0_q);
    end
  end

  // Read mux; unmapped words read zero
  always_comb
  begin
    rdata_d = 16'h0000;
    unique case (addr)
      ifeb_pkg::OFS_FLAGS3:     rdata_d = flag_q[0];
      ifeb_pkg::OFS_FLAGS4:     rdata_d = flag_q[1];
      ifeb_pkg::OFS_FLAGS5:     rdata_d = flag_q[2];
      ifeb_pkg::OFS_ENABLES0:   rdata_d = en0_q;
      ifeb_pkg::OFS_IRQ_STATUS: rdata_d = {13'h0000, status_q};
      ifeb_pkg::OFS_IRQ_MASK:   rdata_d = {13'h0000, mask_q};
      default:                  rdata_d = 16'h0000;
    endcase
  end

  // One wait cycle per access: data is snapshotted on the same edge that drops waitrequest
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end
    else if ((avs_req.read || avs_req.write) && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= {16'h0000, avs_req.read ? rdata_d : 16'h0000};
    end
    else
    begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Helper: low during reset and in the first cycle after reset release
  logic init_q;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      init_q <= 1'b0;
    end
    else
    begin
      init_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  reset_zero_a: assert property (
    !init_q |-> (flag_q[0] == 16'h0000 && flag_q[1] == 16'h0000
                 && flag_q[2] == 16'h0000 && en0_q == 16'h0000))
    else $error("registers not zero after reset");

  flag3_unimpl_a: assert property (
    (flag_q[0] & ~ifeb_pkg::MASK_FLAGS3) == 16'h0000)
    else $error("unimplemented third flag bit set");

  flag4_unimpl_a: assert property (
    (flag_q[1] & ~ifeb_pkg::MASK_FLAGS4) == 16'h0000)
    else $error("unimplemented fourth flag bit set");

  calendar_set_a: assert property (
    src_flags3.calendar_clock_flag |=> flag_q[0][14]
      ##1 (req3.calendar_clock_flag == $past(en3_in[14])))
    else $error("calendar flag not at bit 14");

  time_measure_set_a: assert property (
    src_flags4.time_measure_flag |=> flag_q[1][13])
    else $error("time measure flag not at bit 13");

  capture9_set_a: assert property (
    src_flags5.capture9_flag |=> flag_q[2][13] && (flag_q[2][15:14] == 2'b00))
    else $error("capture9 flag not at bit 13");

  usb_set_a: assert property (
    src_flags5.usb_event_flag |=> flag_q[2][6] && !flag_q[2][0])
    else $error("usb flag not at bit 6");

  enable_write_a: assert property (
    (wr_acc && addr == ifeb_pkg::OFS_ENABLES0 && avs_req.byteenable[1:0] == 2'b11)
      |=> en0_q == ($past(avs_req.writedata[15:0]) & ifeb_pkg::MASK_ENABLES0))
    else $error("enable write not stored");

  enable_bit4_a: assert property (
    !en0_q[4] && en0_q[15:14] == 2'b00)
    else $error("unimplemented enable bit set");

  flag_write_a: assert property (
    (wr_acc && addr == ifeb_pkg::OFS_FLAGS5 && avs_req.byteenable[1:0] == 2'b11
      && set_v[2] == 16'h0000)
      |=> flag_q[2] == ($past(avs_req.writedata[15:0]) & ifeb_pkg::MASK_FLAGS5))
    else $error("flag write not stored");

  enable_gate_a: assert property (
    ##1 req0 == ($past(flags0_in) & $past(en0_q)))
    else $error("enable gating wrong");

  flag_holds_a: assert property (
    (flag_q[0][14] && !(wr_acc && addr == ifeb_pkg::OFS_FLAGS3)) |=> flag_q[0][14])
    else $error("flag dropped without software clear");

  req_gate_a: assert property (
    ##1 req4 == ($past(flag_q[1]) & $past(en4_in)))
    else $error("request forwarded without flag and enable");

  bus_answer_a: assert property (
    ((avs_req.read || avs_req.write) && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait cycle");

  irq_level_a: assert property (
    ##1 irq == |($past(status_q) & $past(mask_q)))
    else $error("interrupt output mismatch");

  flag5_unimpl_a: assert property (
    (flag_q[2] & ~ifeb_pkg::MASK_FLAGS5) == 16'h0000)
    else $error("unimplemented fifth flag bit set");

  enable_unimpl_a: assert property (
    (en0_q & ~ifeb_pkg::MASK_ENABLES0) == 16'h0000)
    else $error("enable pad bit set");

  ext_input_set_a: assert property (
    src_flags3.ext_input4_flag |=> flag_q[0][6])
    else $error("ext input 4 flag not at bit 6");

  i2c2_set_a: assert property (
    src_flags3.i2c2_master_flag |=> flag_q[0][2])
    else $error("i2c2 master flag not at bit 2");

  low_voltage_set_a: assert property (
    src_flags4.low_voltage_flag |=> flag_q[1][8])
    else $error("low voltage flag not at bit 8");

  crc_set_a: assert property (
    src_flags4.crc_gen_flag |=> flag_q[1][3])
    else $error("crc flag not at bit 3");

  uart4_rx_set_a: assert property (
    src_flags5.uart4_rx_flag |=> flag_q[2][8])
    else $error("uart4 rx flag not at bit 8");

  uart3_error_set_a: assert property (
    src_flags5.uart3_error_flag |=> flag_q[2][1])
    else $error("uart3 error flag not at bit 1");

  set_wins3_a: assert property (
    (set_v[0] != 16'h0000) |=> (flag_q[0] & $past(set_v[0])) == $past(set_v[0]))
    else $error("third flag set lost");

  set_wins4_a: assert property (
    (set_v[1] != 16'h0000) |=> (flag_q[1] & $past(set_v[1])) == $past(set_v[1]))
    else $error("fourth flag set lost");

  set_wins5_a: assert property (
    (set_v[2] != 16'h0000) |=> (flag_q[2] & $past(set_v[2])) == $past(set_v[2]))
    else $error("fifth flag set lost");

  enable_keep_a: assert property (
    !(wr_acc && addr == ifeb_pkg::OFS_ENABLES0) |=> $stable(en0_q))
    else $error("enable register changed without write");

  mask_write_a: assert property (
    (wr_acc && addr == ifeb_pkg::OFS_IRQ_MASK && avs_req.byteenable[0])
      |=> mask_q == ($past(avs_req.writedata[ifeb_pkg::EVT_W-1:0]) & ifeb_pkg::MASK_EVT))
    else $error("mask write not stored");

  status_set_a: assert property (
    (set_v[1] != 16'h0000) |=> status_q[1])
    else $error("status bit not set by event");

  req_gate3_a: assert property (
    ##1 req3 == ($past(flag_q[0]) & $past(en3_in)))
    else $error("third group request wrong");

  req_gate5_a: assert property (
    ##1 req5 == ($past(flag_q[2]) & $past(en5_in)))
    else $error("fifth group request wrong");

  readdata_upper_a: assert property (
    !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");

endmodule // ifeb_top

// ### verification/ifeb_periph.sv
`timescale 1ns/100ps
// Sources give one-cycle pulses, the shortest request the block must catch
module ifeb_periph (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [15:0]      fire3,
  input  wire logic [15:0]      fire4,
  input  wire logic [15:0]      fire5,
  output ifeb_pkg::ifeb_flags3_t src3,
  output ifeb_pkg::ifeb_flags4_t src4,
  output ifeb_pkg::ifeb_flags5_t src5
);
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      src3 <= 16'h0000;
      src4 <= 16'h0000;
      src5 <= 16'h0000;
    end
    else
    begin
      src3 <= fire3;
      src4 <= fire4;
      src5 <= fire5;
    end
  end
endmodule // ifeb_periph

// ### verification/test_ifeb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module test_ifeb_top;
  logic                      clk;
  logic                      nrst;
  ifeb_pkg::ifeb_avs_req_t   avs_req;
  logic [31:0]               avs_readdata;
  logic                      avs_waitrequest;
  logic                      irq;
  logic [15:0]               fire3, fire4, fire5, flags0_in, en3_in, en4_in, en5_in, rdat;
  ifeb_pkg::ifeb_flags3_t    src3, req3;
  ifeb_pkg::ifeb_flags4_t    src4, req4;
  ifeb_pkg::ifeb_flags5_t    src5, req5;
  ifeb_pkg::ifeb_enables0_t  req0;
  logic [15:0]               masks [4];
  int                        miscompares, n_tests, cycles;

  ifeb_periph i_ifeb_periph (.clk(clk), .nrst(nrst), .fire3(fire3), .fire4(fire4),
    .fire5(fire5), .src3(src3), .src4(src4), .src5(src5));
  ifeb_top i_ifeb_top (.clk(clk), .nrst(nrst), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .src_flags3(src3), .src_flags4(src4),
    .src_flags5(src5), .flags0_in(flags0_in), .en3_in(en3_in), .en4_in(en4_in),
    .en5_in(en5_in), .req3(req3), .req4(req4), .req5(req5), .req0(req0), .irq(irq));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic results();
    $display("Comparisons %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One edge passes first so a released strobe is never raised in the same step
  task automatic acc(input logic [4:0] a, input logic w, input logic [15:0] wd,
                     input logic [3:0] be);
    @(posedge clk);
    avs_req <= '{address: a, read: !w, write: w, writedata: {16'h0000, wd}, byteenable: be};
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata[15:0];
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask

  task automatic chk_rd(input logic [4:0] a, input logic [15:0] exp);
    acc(a, 1'b0, 16'h0000, 4'hF);
    `CHK(rdat, exp)
  endtask

  task automatic pulse(input logic [15:0] f3, input logic [15:0] f4, input logic [15:0] f5);
    @(posedge clk);
    fire3 <= f3;
    fire4 <= f4;
    fire5 <= f5;
    @(posedge clk);
    fire3 <= 16'h0000;
    fire4 <= 16'h0000;
    fire5 <= 16'h0000;
    repeat (3) @(posedge clk);
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      results();
    end
  end

  initial
  begin
    nrst = 1'b0;
    avs_req = '0;
    {fire3, fire4, fire5, flags0_in, en3_in, en4_in, en5_in} = '0;
    masks = '{ifeb_pkg::MASK_FLAGS3, ifeb_pkg::MASK_FLAGS4, ifeb_pkg::MASK_FLAGS5,
              ifeb_pkg::MASK_ENABLES0};
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++)
      chk_rd(5'(4 * i), 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      acc(5'(4 * i), 1'b1, 16'hFFFF, 4'hF);
      chk_rd(5'(4 * i), masks[i]);
      acc(5'(4 * i), 1'b1, 16'h0000, 4'hF);
      chk_rd(5'(4 * i), 16'h0000);
    end
    acc(ifeb_pkg::OFS_ENABLES0, 1'b1, 16'hFFFF, 4'h1);
    chk_rd(ifeb_pkg::OFS_ENABLES0, ifeb_pkg::MASK_ENABLES0 & 16'h00FF);
    acc(ifeb_pkg::OFS_ENABLES0, 1'b1, 16'hFFFF, 4'h2);
    chk_rd(ifeb_pkg::OFS_ENABLES0, ifeb_pkg::MASK_ENABLES0);
    // All sources fire, pads included, while the core side is blocked
    pulse(16'hFFFF, 16'hFFFF, 16'hFFFF);
    chk_rd(ifeb_pkg::OFS_FLAGS3, ifeb_pkg::MASK_FLAGS3);
    chk_rd(ifeb_pkg::OFS_FLAGS4, ifeb_pkg::MASK_FLAGS4);
    chk_rd(ifeb_pkg::OFS_FLAGS5, ifeb_pkg::MASK_FLAGS5);
    `CHK(req3, 16'h0000)
    en3_in <= 16'hFFFF;
    en4_in <= 16'h2000;
    en5_in <= 16'hFFFF;
    repeat (3) @(posedge clk);
    `CHK(req3, ifeb_pkg::MASK_FLAGS3)
    `CHK(req4, 16'h2000)
    `CHK(req5, ifeb_pkg::MASK_FLAGS5)
    acc(ifeb_pkg::OFS_FLAGS3, 1'b1, 16'h0000, 4'hF);
    repeat (3) @(posedge clk);
    `CHK(req3, 16'h0000)
    chk_rd(ifeb_pkg::OFS_FLAGS5, ifeb_pkg::MASK_FLAGS5);
    flags0_in <= 16'hFFFF;
    acc(ifeb_pkg::OFS_ENABLES0, 1'b1, 16'h0101, 4'h3);
    repeat (3) @(posedge clk);
    `CHK(req0, 16'h0101)
    chk_rd(ifeb_pkg::OFS_IRQ_STATUS, 16'h0007);
    chk_rd(ifeb_pkg::OFS_IRQ_STATUS, 16'h0000);
    pulse(16'h0000, 16'h0100, 16'h0000);
    `CHK(irq, 1'b0)
    acc(ifeb_pkg::OFS_IRQ_MASK, 1'b1, 16'h0002, 4'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    chk_rd(ifeb_pkg::OFS_IRQ_STATUS, 16'h0002);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    acc(5'h18, 1'b1, 16'hFFFF, 4'hF);
    chk_rd(5'h18, 16'h0000);
    chk_rd(ifeb_pkg::OFS_IRQ_MASK, 16'h0002);
    chk_rd(ifeb_pkg::OFS_FLAGS4, ifeb_pkg::MASK_FLAGS4);
    results();
  end
endmodule // test_ifeb_top
